//--- logic/synth_ctrl_device.sv
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ns
module synth_ctrl_device
	import synth_ctrl_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	synth_link_if.dev        link,
	input  wire logic        lock_warning_n_i,
	output logic             aux_output_pin_o,
	output logic [1:0]       if_output_divide_o,
	output logic             if_low_bias_o,
	output logic             extended_band_bit_o,
	output logic             if_section_on_o,
	output logic             rf_section_on_o,
	output logic             ref_amp_on_o,
	output logic [1:0]       if_gain_code_o,
	output logic [1:0]       band2_gain_code_o,
	output logic [1:0]       band1_gain_code_o,
	output logic [17:0]      band1_feedback_count_o,
	output logic [16:0]      band2_feedback_count_o,
	output logic [15:0]      if_feedback_count_o,
	output logic [12:0]      band1_ref_count_o,
	output logic [12:0]      band2_ref_count_o,
	output logic [12:0]      if_ref_count_o,
	output logic             rf_band2_select_o,
	output logic             reg_write_o,
	output logic [3:0]       reg_write_addr_o
);

	logic [3:0]  sync1_q;
	logic [3:0]  sync2_q;
	logic        clk_prev_q;
	logic        en_prev_q;
	logic [21:0] shift_q;
	logic [4:0]  bit_cnt_q;
	logic [17:0] regs_q [REG_COUNT];
	logic        clk_rise;
	logic        frame_end;
	logic        frame_ok;
	logic        write_en;
	logic [3:0]  wr_addr;
	logic [17:0] wr_data;
	logic        link_clk_s;
	logic        link_data_s;
	logic        link_en_n_s;
	logic        lock_n_s;
	logic [17:0] main_cfg;
	logic [17:0] power_cfg;
	logic        auto_gain;

	// Every link input and the lock warning pass two flops before use
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_q <= SYNC_RESET;
			sync2_q <= SYNC_RESET;
		end else begin
			sync1_q <= {link.link_clk, link.link_data,
				link.link_enable_n, lock_warning_n_i};
			sync2_q <= sync1_q;
		end
	end

	assign link_clk_s  = sync2_q[3];
	assign link_data_s = sync2_q[2];
	assign link_en_n_s = sync2_q[1];
	assign lock_n_s    = sync2_q[0];

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clk_prev_q <= 1'b0;
			en_prev_q  <= 1'b1;
		end else begin
			clk_prev_q <= link_clk_s;
			en_prev_q  <= link_en_n_s;
		end
	end

	assign clk_rise  = link_clk_s & ~clk_prev_q;
	assign frame_end = link_en_n_s & ~en_prev_q;

	// Bits are taken on the link clock rising edge while enabled
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift_q <= 22'h000000;
		end else if (!link_en_n_s && clk_rise) begin
			shift_q <= {shift_q[20:0], link_data_s};
		end
	end

	// Saturating count; a frame of the wrong length is dropped
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bit_cnt_q <= 5'h00;
		end else if (link_en_n_s) begin
			bit_cnt_q <= 5'h00;
		end else if (clk_rise && bit_cnt_q != 5'h1F) begin
			bit_cnt_q <= bit_cnt_q + 5'h01;
		end
	end

	assign frame_ok = frame_end & (bit_cnt_q == FRAME_LEN);
	assign wr_addr  = shift_q[3:0];
	assign wr_data  = shift_q[21:4];
	// Unassigned addresses are dropped rather than aliased
	assign write_en = frame_ok & (wr_addr <= LAST_VALID_ADDR);

	// Write-only store; no path back to the link
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				regs_q[i] <= REG_RESET;
			end
		end else if (write_en) begin
			regs_q[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_write_o      <= 1'b0;
			reg_write_addr_o <= 4'h0;
		end else begin
			reg_write_o <= write_en;
			if (write_en) begin
				reg_write_addr_o <= wr_addr;
			end
		end
	end

	// Last band divider written picks the RF oscillator
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rf_band2_select_o <= 1'b0;
		end else if (write_en) begin
			if (wr_addr == BAND1_FEEDBACK_ADDR
				|| wr_addr == BAND1_REF_ADDR) begin
				rf_band2_select_o <= 1'b0;
			end else if (wr_addr == BAND2_FEEDBACK_ADDR
				|| wr_addr == BAND2_REF_ADDR) begin
				rf_band2_select_o <= 1'b1;
			end
		end
	end

	assign main_cfg  = regs_q[MAIN_CONFIG_ADDR];
	assign power_cfg = regs_q[SECTION_POWER_ADDR];
	assign auto_gain = main_cfg[AUTO_GAIN_BIT];

	// Reserved select codes also hold the pin low
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aux_output_pin_o <= 1'b0;
		end else begin
			case (main_cfg[AUX_SEL_LSB +: 2])
				AUX_LOCK_WARN: aux_output_pin_o <= lock_n_s;
				AUX_FORCE_LOW: aux_output_pin_o <= 1'b0;
				default:       aux_output_pin_o <= 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			if_output_divide_o  <= 2'h0;
			if_low_bias_o       <= 1'b0;
			extended_band_bit_o <= 1'b0;
		end else begin
			if_output_divide_o  <= main_cfg[IF_DIV_LSB +: 2];
			if_low_bias_o       <= main_cfg[IF_LOW_BIAS_BIT];
			extended_band_bit_o <= main_cfg[EXT_BAND_BIT];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			if_section_on_o <= 1'b0;
			rf_section_on_o <= 1'b0;
			ref_amp_on_o    <= 1'b0;
		end else begin
			if_section_on_o <= main_cfg[AUTO_POWER_BIT]
				| power_cfg[IF_ON_BIT];
			rf_section_on_o <= main_cfg[AUTO_POWER_BIT]
				| power_cfg[RF_ON_BIT];
			ref_amp_on_o    <= main_cfg[AUTO_POWER_BIT]
				| power_cfg[IF_ON_BIT]
				| power_cfg[RF_ON_BIT];
		end
	end

	// Auto codes follow the N values as they stand now
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			if_gain_code_o    <= 2'h0;
			band2_gain_code_o <= 2'h0;
			band1_gain_code_o <= 2'h0;
		end else if (auto_gain) begin
			if_gain_code_o    <= gain_for_n(regs_q[IF_FEEDBACK_ADDR],
				IF_GAIN_BASE);
			band2_gain_code_o <= gain_for_n(regs_q[BAND2_FEEDBACK_ADDR],
				BAND2_GAIN_BASE);
			band1_gain_code_o <= gain_for_n(regs_q[BAND1_FEEDBACK_ADDR],
				BAND1_GAIN_BASE);
		end else begin
			if_gain_code_o    <=
				regs_q[DETECTOR_GAIN_ADDR][IF_GAIN_LSB +: 2];
			band2_gain_code_o <=
				regs_q[DETECTOR_GAIN_ADDR][BAND2_GAIN_LSB +: 2];
			band1_gain_code_o <=
				regs_q[DETECTOR_GAIN_ADDR][BAND1_GAIN_LSB +: 2];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			band1_feedback_count_o <= 18'h00000;
			band2_feedback_count_o <= 17'h00000;
			if_feedback_count_o    <= 16'h0000;
		end else begin
			band1_feedback_count_o <= regs_q[BAND1_FEEDBACK_ADDR];
			band2_feedback_count_o <= regs_q[BAND2_FEEDBACK_ADDR][16:0];
			if_feedback_count_o    <= regs_q[IF_FEEDBACK_ADDR][15:0];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			band1_ref_count_o <= 13'h0000;
			band2_ref_count_o <= 13'h0000;
			if_ref_count_o    <= 13'h0000;
		end else begin
			band1_ref_count_o <= regs_q[BAND1_REF_ADDR][12:0];
			band2_ref_count_o <= regs_q[BAND2_REF_ADDR][12:0];
			if_ref_count_o    <= regs_q[IF_REF_ADDR][12:0];
		end
	end

endmodule : synth_ctrl_device

//--- logic/synth_ctrl_host.sv
`timescale 1ns/1ns
module synth_ctrl_host
	import synth_ctrl_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	input  wire logic [3:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	synth_link_if.host       link
);

	typedef enum logic [2:0] {
		ST_IDLE, ST_LOW, ST_HIGH, ST_TAIL, ST_GAP
	} frame_state_e;

	frame_state_e state_q;
	logic [2:0]   div_q;
	logic [4:0]   bit_cnt_q;
	logic [21:0]  shift_q;
	logic         ack_q;
	logic         refused_q;
	logic [17:0]  data_q;
	logic [3:0]   last_addr_q;
	logic         auto_gain_q;
	logic [5:0]   gain_last_q;
	logic [17:0]  n_band1_q;
	logic [17:0]  n_band2_q;
	logic [17:0]  n_if_q;
	logic         busy;
	logic         req;
	logic         blocked;
	logic         do_write;
	logic         tick;
	logic         start;
	logic [3:0]   cmd_addr;
	logic [17:0]  payload;
	logic [5:0]   gain_eff;
	logic [1:0]   loop_gain;

	assign busy     = (state_q != ST_IDLE);
	assign req      = avs_read_i | avs_write_i;
	assign blocked  = avs_write_i & (avs_address_i == HOST_CMD_OFF) & busy;
	assign avs_waitrequest_o = req & ~ack_q;
	assign do_write = avs_write_i & ack_q;
	assign cmd_addr = avs_writedata_i[3:0];
	assign start    = do_write & (avs_address_i == HOST_CMD_OFF)
		& (cmd_addr <= LAST_VALID_ADDR);
	assign tick     = (div_q == DIV_LAST);

	// Effective codes the device will use, for the R range check
	always_comb begin
		gain_eff = gain_last_q;
		if (auto_gain_q) begin
			gain_eff = {gain_for_n(n_if_q, IF_GAIN_BASE),
				gain_for_n(n_band2_q, BAND2_GAIN_BASE),
				gain_for_n(n_band1_q, BAND1_GAIN_BASE)};
		end
	end

	always_comb begin
		payload   = data_q;
		loop_gain = gain_eff[5:4];
		if (cmd_addr == BAND1_REF_ADDR) begin
			loop_gain = gain_eff[1:0];
		end else if (cmd_addr == BAND2_REF_ADDR) begin
			loop_gain = gain_eff[3:2];
		end
		if (cmd_addr == DETECTOR_GAIN_ADDR
			&& avs_writedata_i[CMD_FILL_BIT]) begin
			payload = {12'h000, gain_for_n(n_if_q, IF_GAIN_BASE),
				gain_for_n(n_band2_q, BAND2_GAIN_BASE),
				gain_for_n(n_band1_q, BAND1_GAIN_BASE)};
		end else if (cmd_addr >= BAND1_REF_ADDR) begin
			if (data_q[12:0] < r_min(loop_gain)) begin
				payload = {5'h00, r_min(loop_gain)};
			end else if (data_q[12:0] > R_MAX) begin
				payload = {5'h00, R_MAX};
			end
		end
		payload = payload & reg_mask(cmd_addr);
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q & ~blocked;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			avs_readdata_o <= 32'h00000000;
		end else if (req & ~ack_q & ~blocked) begin
			if (avs_address_i == HOST_DATA_OFF) begin
				avs_readdata_o <= {14'h0000, data_q};
			end else if (avs_address_i == HOST_CMD_OFF) begin
				avs_readdata_o <= {28'h0000000, last_addr_q};
			end else if (avs_address_i == HOST_STATUS_OFF) begin
				avs_readdata_o <= {30'h00000000, refused_q, busy};
			end else begin
				avs_readdata_o <= 32'h00000000;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			data_q <= REG_RESET;
		end else if (do_write && avs_address_i == HOST_DATA_OFF) begin
			data_q <= avs_writedata_i[17:0];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			refused_q   <= 1'b0;
			last_addr_q <= 4'h0;
		end else if (do_write && avs_address_i == HOST_CMD_OFF) begin
			refused_q   <= ~start;
			last_addr_q <= cmd_addr;
		end
	end

	// Shadow of what was sent, for gain fill and R range checks
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			auto_gain_q <= 1'b0;
			gain_last_q <= 6'h00;
			n_band1_q   <= REG_RESET;
			n_band2_q   <= REG_RESET;
			n_if_q      <= REG_RESET;
		end else if (start) begin
			if (cmd_addr == MAIN_CONFIG_ADDR) begin
				auto_gain_q <= payload[AUTO_GAIN_BIT];
			end else if (cmd_addr == DETECTOR_GAIN_ADDR) begin
				gain_last_q <= payload[5:0];
			end else if (cmd_addr == BAND1_FEEDBACK_ADDR) begin
				n_band1_q <= payload;
			end else if (cmd_addr == BAND2_FEEDBACK_ADDR) begin
				n_band2_q <= payload;
			end else if (cmd_addr == IF_FEEDBACK_ADDR) begin
				n_if_q <= payload;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_q <= 3'h0;
		end else if (start || !busy || tick) begin
			div_q <= 3'h0;
		end else begin
			div_q <= div_q + 3'h1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q            <= ST_IDLE;
			shift_q            <= 22'h000000;
			bit_cnt_q          <= 5'h00;
			link.link_clk      <= 1'b0;
			link.link_data     <= 1'b0;
			link.link_enable_n <= 1'b1;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start) begin
						// Data MSB first, address last
						shift_q            <= {payload, cmd_addr};
						link.link_data     <= payload[17];
						link.link_enable_n <= 1'b0;
						bit_cnt_q          <= 5'h00;
						state_q            <= ST_LOW;
					end
				end
				ST_LOW: begin
					if (tick) begin
						link.link_clk <= 1'b1;
						state_q       <= ST_HIGH;
					end
				end
				ST_HIGH: begin
					if (tick) begin
						link.link_clk <= 1'b0;
						if (bit_cnt_q == FRAME_LEN - 5'h01) begin
							state_q <= ST_TAIL;
						end else begin
							shift_q        <= {shift_q[20:0], 1'b0};
							link.link_data <= shift_q[20];
							bit_cnt_q      <= bit_cnt_q + 5'h01;
							state_q        <= ST_LOW;
						end
					end
				end
				ST_TAIL: begin
					if (tick) begin
						link.link_enable_n <= 1'b1;
						state_q            <= ST_GAP;
					end
				end
				default: begin
					if (tick) begin
						state_q <= ST_IDLE;
					end
				end
			endcase
		end
	end

endmodule : synth_ctrl_host

//--- logic/synth_ctrl_pkg.sv
// Contract
// - Address 0 selects 18-bit main configuration
// - Address 1 holds three 2-bit gain codes
// - Host never writes addresses 9 to 15
// - Host writes zero into reserved bits
// - Aux pin: 01 low, 11 lock warning
// - IF output divide: 1, 2, 4, 8
// - Bit 5 selects reduced IF output bias
// - Auto power-up forces both sections on
// - Auto gain derives codes from N values
// - Host IF gain code from N thresholds
// - Host band 2 gain code from N
// - Host band 1 gain code from N
// - Host loads gain codes unless auto
// - Power bit 1 IF on, bit 0 RF
// - Any section on powers reference amplifier
// - Host keeps R within gain-dependent range
package synth_ctrl_pkg;

	localparam int          DATA_W     = 18;
	localparam int          ADDR_W     = 4;
	localparam int          FRAME_BITS = DATA_W + ADDR_W;
	localparam int          REG_COUNT  = 9;
	localparam logic [4:0]  FRAME_LEN  = 5'(FRAME_BITS);
	localparam logic [17:0] REG_RESET  = 18'h00000;

	localparam logic [3:0] MAIN_CONFIG_ADDR      = 4'h0;
	localparam logic [3:0] DETECTOR_GAIN_ADDR    = 4'h1;
	localparam logic [3:0] SECTION_POWER_ADDR    = 4'h2;
	localparam logic [3:0] BAND1_FEEDBACK_ADDR   = 4'h3;
	localparam logic [3:0] BAND2_FEEDBACK_ADDR   = 4'h4;
	localparam logic [3:0] IF_FEEDBACK_ADDR      = 4'h5;
	localparam logic [3:0] BAND1_REF_ADDR        = 4'h6;
	localparam logic [3:0] BAND2_REF_ADDR        = 4'h7;
	localparam logic [3:0] IF_REF_ADDR           = 4'h8;
	localparam logic [3:0] LAST_VALID_ADDR       = 4'h8;

	localparam int AUX_SEL_LSB      = 12;
	localparam int IF_DIV_LSB       = 10;
	localparam int IF_LOW_BIAS_BIT  = 5;
	localparam int AUTO_POWER_BIT   = 3;
	localparam int AUTO_GAIN_BIT    = 2;
	localparam int EXT_BAND_BIT     = 1;
	localparam int IF_GAIN_LSB      = 4;
	localparam int BAND2_GAIN_LSB   = 2;
	localparam int BAND1_GAIN_LSB   = 0;
	localparam int IF_ON_BIT        = 1;
	localparam int RF_ON_BIT        = 0;

	localparam logic [1:0] AUX_FORCE_LOW = 2'h1;
	localparam logic [1:0] AUX_LOCK_WARN = 2'h3;

	localparam logic [17:0] IF_GAIN_BASE    = 18'h00800;
	localparam logic [17:0] BAND2_GAIN_BASE = 18'h01000;
	localparam logic [17:0] BAND1_GAIN_BASE = 18'h02000;

	localparam logic [12:0] R_MAX    = 13'h1FFD;
	localparam logic [12:0] R_MIN_G0 = 13'h0007;
	localparam logic [12:0] R_MIN_G1 = 13'h0008;
	localparam logic [12:0] R_MIN_G2 = 13'h000A;
	localparam logic [12:0] R_MIN_G3 = 13'h000E;

	// Synchroniser idle: link clock low, data low, enable high, lock high
	localparam logic [3:0] SYNC_RESET = 4'h3;

	localparam logic [3:0] HOST_DATA_OFF   = 4'h0;
	localparam logic [3:0] HOST_CMD_OFF    = 4'h4;
	localparam logic [3:0] HOST_STATUS_OFF = 4'h8;
	localparam int         CMD_FILL_BIT    = 8;
	localparam int         STAT_BUSY_BIT   = 0;
	localparam int         STAT_REFUSE_BIT = 1;

	localparam int         CLK_PERIOD_NS    = 10;
	localparam int         LINK_HALF_NS     = 40;
	localparam int         LINK_HALF_CYCLES =
		(LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] DIV_LAST         = 3'(LINK_HALF_CYCLES - 1);

	function automatic logic [1:0] gain_for_n(input logic [17:0] n,
		input logic [17:0] base);
		if (n < base) begin
			return 2'h0;
		end else if (n < {base[16:0], 1'b0}) begin
			return 2'h1;
		end else if (n < {base[15:0], 2'b00}) begin
			return 2'h2;
		end
		return 2'h3;
	endfunction : gain_for_n

	function automatic logic [12:0] r_min(input logic [1:0] code);
		case (code)
			2'h0:    return R_MIN_G0;
			2'h1:    return R_MIN_G1;
			2'h2:    return R_MIN_G2;
			default: return R_MIN_G3;
		endcase
	endfunction : r_min

	function automatic logic [17:0] reg_mask(input logic [3:0] addr);
		if (addr == MAIN_CONFIG_ADDR) begin
			return 18'h03C2C;
		end else if (addr == DETECTOR_GAIN_ADDR) begin
			return 18'h0003F;
		end else if (addr == SECTION_POWER_ADDR) begin
			return 18'h00003;
		end else if (addr == BAND1_FEEDBACK_ADDR) begin
			return 18'h3FFFF;
		end else if (addr == BAND2_FEEDBACK_ADDR) begin
			return 18'h1FFFF;
		end else if (addr == IF_FEEDBACK_ADDR) begin
			return 18'h0FFFF;
		end else if (addr <= LAST_VALID_ADDR) begin
			return 18'h01FFF;
		end
		return 18'h00000;
	endfunction : reg_mask

endpackage : synth_ctrl_pkg

//--- logic/synth_link_if.sv
`timescale 1ns/1ns
interface synth_link_if;
	logic link_clk;
	logic link_data;
	logic link_enable_n;

	modport dev (
		input link_clk,
		input link_data,
		input link_enable_n
	);

	modport host (
		output link_clk,
		output link_data,
		output link_enable_n
	);
endinterface : synth_link_if

//--- tb/synth_link_monitor.sv
`timescale 1ns/1ns
module synth_link_monitor (
	input  wire logic clk_sys_i,
	input  wire logic rst_n_i,
	input  wire logic link_clk,
	input  wire logic link_data,
	input  wire logic link_enable_n
);
	logic [4:0]  bits_q;
	logic [21:0] shift_q;
	logic        clk_prev_q;
	wire logic   clk_rise = link_clk && !clk_prev_q;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) clk_prev_q <= 1'b0;
		else clk_prev_q <= link_clk;
	end
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) bits_q <= 5'h00;
		else if (link_enable_n) bits_q <= 5'h00;
		else if (clk_rise) bits_q <= bits_q + 5'h01;
	end
	// Keeps the last frame after enable rises for the end checks
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) shift_q <= 22'h000000;
		else if (!link_enable_n && clk_rise)
			shift_q <= {shift_q[20:0], link_data};
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	idle_clk_low_a: assert property (link_enable_n |-> !link_clk)
		else $error("link clock high outside a frame");
	clk_high_len_a: assert property ($rose(link_clk) |->
		link_clk [*4] ##1 !link_clk) else $error("link clock high time");
	clk_low_len_a: assert property ($fell(link_clk) |-> !link_clk [*4])
		else $error("link clock low time");
	data_hold_a: assert property (link_clk && $past(link_clk) |->
		$stable(link_data)) else $error("data moved while clock high");
	frame_start_a: assert property ($fell(link_enable_n) |->
		!link_clk [*4]) else $error("frame start timing");
	frame_bits_a: assert property ($rose(link_enable_n) |->
		bits_q == 5'd22) else $error("frame length not 22 bits");
	frame_end_a: assert property ($fell(link_enable_n) |->
		##[170:260] $rose(link_enable_n)) else $error("frame too long");
	addr_legal_a: assert property ($rose(link_enable_n) |->
		shift_q[3:0] <= 4'h8) else $error("reserved address sent");
	reserved_zero_a: assert property ($rose(link_enable_n) &&
		shift_q[3:0] == 4'h0 |-> (shift_q[21:4] & 18'h3C3D3) == 18'h0)
		else $error("reserved bit set in main config");
	ref_range_a: assert property ($rose(link_enable_n) &&
		shift_q[3:0] inside {4'h6, 4'h7, 4'h8} |-> shift_q[21:17] == 5'h0
		&& shift_q[16:4] >= 13'd7 && shift_q[16:4] <= 13'd8189)
		else $error("ref divider out of range");
	gap_a: assert property ($rose(link_enable_n) |-> link_enable_n [*4])
		else $error("gap between frames too short");

	cover property ($rose(link_enable_n) && shift_q[3:0] == 4'h0);
	cover property ($rose(link_enable_n) && shift_q[3:0] == 4'h1);
	cover property ($rose(link_enable_n) && shift_q[3:0] == 4'h8);
endmodule : synth_link_monitor

//--- tb/test_synth_control_register_bank.sv
`timescale 1ns/1ns
module test_synth_control_register_bank;
	import synth_ctrl_pkg::*;
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
	failures++; $display("[ERR] %s expected %0h seen %0h", nm, ex, got); \
	end end
	logic clk_sys_i, rst_n_i, avs_read_i, avs_write_i, lock_warning_n_i;
	logic [3:0]  avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o;
	logic        avs_waitrequest_o, aux_output_pin_o, if_low_bias_o;
	logic        extended_band_bit_o, if_section_on_o, rf_section_on_o;
	logic        ref_amp_on_o, rf_band2_select_o, reg_write_o;
	logic [1:0]  if_output_divide_o, if_gain_code_o;
	logic [1:0]  band2_gain_code_o, band1_gain_code_o;
	logic [17:0] band1_feedback_count_o;
	logic [16:0] band2_feedback_count_o;
	logic [15:0] if_feedback_count_o;
	logic [12:0] band1_ref_count_o, band2_ref_count_o, if_ref_count_o;
	logic [3:0]  reg_write_addr_o;
	int          failures, cmp_count, cycles;

	synth_link_if synth_link_if_inst ();
	synth_ctrl_host synth_ctrl_host_inst (.clk_sys_i, .rst_n_i,
		.avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
		.avs_readdata_o, .avs_waitrequest_o, .link(synth_link_if_inst));
	synth_ctrl_device synth_ctrl_device_inst (.clk_sys_i, .rst_n_i,
		.link(synth_link_if_inst), .lock_warning_n_i, .aux_output_pin_o,
		.if_output_divide_o, .if_low_bias_o, .extended_band_bit_o,
		.if_section_on_o, .rf_section_on_o, .ref_amp_on_o, .if_gain_code_o,
		.band2_gain_code_o, .band1_gain_code_o, .band1_feedback_count_o,
		.band2_feedback_count_o, .if_feedback_count_o, .band1_ref_count_o,
		.band2_ref_count_o, .if_ref_count_o, .rf_band2_select_o,
		.reg_write_o, .reg_write_addr_o);
	synth_link_monitor synth_link_monitor_inst (.clk_sys_i, .rst_n_i,
		.link_clk(synth_link_if_inst.link_clk),
		.link_data(synth_link_if_inst.link_data),
		.link_enable_n(synth_link_if_inst.link_enable_n));

	always #5 clk_sys_i = ~clk_sys_i;

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : final_report

	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			final_report();
		end
	end

	task automatic av_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= 1'b1;
		do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
		avs_write_i <= 1'b0;
	endtask : av_wr

	task automatic av_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys_i);
		avs_address_i <= a;
		avs_read_i <= 1'b1;
		do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
		d = avs_readdata_o;
		avs_read_i <= 1'b0;
	endtask : av_rd

	task automatic send(input logic [3:0] a, input logic [17:0] d);
		int          n;
		logic [31:0] st;
		av_wr(HOST_DATA_OFF, {14'h0, d});
		av_wr(HOST_CMD_OFF, {28'h0, a});
		av_rd(HOST_STATUS_OFF, st);
		`CHK("busy flag", 1'b1, st[STAT_BUSY_BIT])
		n = 0;
		while (reg_write_o !== 1'b1 && n < 600) begin
			@(posedge clk_sys_i);
			n++;
		end
		`CHK("write seen", 1'b1, reg_write_o)
		`CHK("write address", a, reg_write_addr_o)
		repeat (2) @(posedge clk_sys_i);
	endtask : send

	task automatic t_refuse();
		logic [31:0] st;
		int          n;
		int          t0;
		av_wr(HOST_CMD_OFF, 32'h00000009);
		av_rd(HOST_STATUS_OFF, st);
		`CHK("refused flag", 1'b1, st[STAT_REFUSE_BIT])
		av_rd(HOST_CMD_OFF, st);
		`CHK("last command", 32'h00000009, st)
		n = 0;
		repeat (300) @(posedge clk_sys_i) if (reg_write_o === 1'b1) n++;
		`CHK("refused writes", 0, n)
		av_rd(4'hC, st);
		`CHK("unmapped read", 32'h0, st)
		send(SECTION_POWER_ADDR, 18'h00003);
		av_rd(HOST_STATUS_OFF, st);
		`CHK("refused cleared", 1'b0, st[STAT_REFUSE_BIT])
		// Second command must wait for the first frame to finish
		av_wr(HOST_CMD_OFF, 32'h00000002);
		t0 = cycles;
		av_wr(HOST_CMD_OFF, 32'h00000002);
		`CHK("held while busy", 1'b1, (cycles - t0) > 170)
		n = 0;
		repeat (300) @(posedge clk_sys_i) if (reg_write_o === 1'b1) n++;
		`CHK("second frame", 1, n)
	endtask : t_refuse

	task automatic t_main();
		logic [1:0] k;
		for (int i = 0; i < 4; i++) begin
			k = 2'(i);
			// Bit 1 set on purpose: the host must clear it
			send(MAIN_CONFIG_ADDR, {4'h0, k[1] ? 2'h3 : 2'h1, k, 4'h0, k[0],
				5'h02});
			`CHK("if divide", k, if_output_divide_o)
			`CHK("low bias", k[0], if_low_bias_o)
			`CHK("ext band", 1'b0, extended_band_bit_o)
			`CHK("aux pin", k[1], aux_output_pin_o)
		end
		lock_warning_n_i <= 1'b0;
		repeat (6) @(posedge clk_sys_i);
		`CHK("aux lock", 1'b0, aux_output_pin_o)
		lock_warning_n_i <= 1'b1;
	endtask : t_main

	task automatic t_power();
		logic [1:0] q;
		for (int i = 3; i >= 0; i--) begin
			q = 2'(i);
			send(SECTION_POWER_ADDR, {16'h0, q});
			`CHK("if on", q[1], if_section_on_o)
			`CHK("rf on", q[0], rf_section_on_o)
			`CHK("ref amp", |q, ref_amp_on_o)
		end
		send(MAIN_CONFIG_ADDR, 18'h03828);
		`CHK("auto if on", 1'b1, if_section_on_o)
		`CHK("auto rf on", 1'b1, rf_section_on_o)
		send(MAIN_CONFIG_ADDR, 18'h03820);
		`CHK("manual if off", 1'b0, if_section_on_o)
	endtask : t_power

	task automatic t_gain();
		send(BAND2_FEEDBACK_ADDR, 18'd9000);
		`CHK("band2 n", 17'd9000, band2_feedback_count_o)
		`CHK("band2 sel", 1'b1, rf_band2_select_o)
		send(BAND1_FEEDBACK_ADDR, 18'd40000);
		`CHK("band1 n", 18'd40000, band1_feedback_count_o)
		`CHK("band1 sel", 1'b0, rf_band2_select_o)
		send(IF_FEEDBACK_ADDR, 18'd3000);
		`CHK("if n", 16'd3000, if_feedback_count_o)
		send(DETECTOR_GAIN_ADDR, 18'h00024);
		`CHK("if gain", 2'h2, if_gain_code_o)
		`CHK("b2 gain", 2'h1, band2_gain_code_o)
		`CHK("b1 gain", 2'h0, band1_gain_code_o)
		send(BAND1_REF_ADDR, 18'd100);
		`CHK("b1 r", 13'd100, band1_ref_count_o)
		send(BAND2_REF_ADDR, 18'd5);
		`CHK("b2 r min", 13'd8, band2_ref_count_o)
		send(IF_REF_ADDR, 18'h01FFF);
		`CHK("if r max", 13'd8189, if_ref_count_o)
		send(MAIN_CONFIG_ADDR, 18'h03824);
		`CHK("auto if", 2'h1, if_gain_code_o)
		`CHK("auto b2", 2'h2, band2_gain_code_o)
		`CHK("auto b1", 2'h3, band1_gain_code_o)
		send(BAND1_FEEDBACK_ADDR, 18'd10000);
		`CHK("new b1", 2'h1, band1_gain_code_o)
		send(MAIN_CONFIG_ADDR, 18'h03820);
		`CHK("manual if", 2'h2, if_gain_code_o)
		`CHK("manual b1", 2'h0, band1_gain_code_o)
		// Fill bit: data word ignored, codes come from last N values
		av_wr(HOST_DATA_OFF, 32'h0003FFFF);
		av_wr(HOST_CMD_OFF, 32'h00000101);
		repeat (200) @(posedge clk_sys_i);
		`CHK("fill if", 2'h1, if_gain_code_o)
		`CHK("fill b2", 2'h2, band2_gain_code_o)
		`CHK("fill b1", 2'h1, band1_gain_code_o)
	endtask : t_gain

	initial begin
		clk_sys_i = 1'b0;
		rst_n_i = 1'b0;
		avs_address_i = 4'h0;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_writedata_i = 32'h0;
		lock_warning_n_i = 1'b1;
		repeat (5) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		t_refuse();
		t_main();
		t_power();
		t_gain();
		final_report();
	end
endmodule : test_synth_control_register_bank
